// ### core/sbsb_pkg.sv
// Shared constants, types and beat sizing for the system bus start-up block.
// Assumes both bus ends run on one clock and share this package.
package sbsb_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int DATA_W = 64;
    localparam int LINE_W = 256;
    localparam int LINE_OFS_BITS = 5;
    localparam int SIZE_W = 4;
    localparam int BEAT_CNT_W = 3;

    // ------------------------------------------------------------
    // Beat counts
    // ------------------------------------------------------------
    localparam logic [3:0] SINGLE_BEATS = 4'h1;
    localparam logic [3:0] NARROW_DWORD_BEATS = 4'h2;
    localparam logic [3:0] WIDE_LINE_BEATS = 4'h4;
    localparam logic [3:0] NARROW_LINE_BEATS = 4'h8;
    localparam logic [3:0] NARROW_BEAT_BYTES = 4'h4;

    // ------------------------------------------------------------
    // Start-up strap and reset values
    // ------------------------------------------------------------
    // Quiesce acknowledge level that selects the 32-bit data bus
    localparam logic NARROW_STRAP_LEVEL = 1'b0;
    localparam logic RESET_NARROW = 1'b0;
    localparam logic NO_RETRY_MODE = 1'b1;
    localparam int MEM_DEPTH_DEFAULT = 64;

    typedef enum logic [1:0] {
        SBSB_INVALID,
        SBSB_EXCLUSIVE,
        SBSB_MODIFIED
    } sbsb_mei_t;

    // Number of data beats for one transaction
    function automatic logic [3:0] sbsb_beats(input logic narrow,
                                              input logic burst,
                                              input logic [3:0] size);
        if (burst) begin
            return narrow ? NARROW_LINE_BEATS : WIDE_LINE_BEATS;
        end
        if (narrow && (size > NARROW_BEAT_BYTES)) begin
            return NARROW_DWORD_BEATS;
        end
        return SINGLE_BEATS;
    endfunction

endpackage

// ### core/sbsb_bus_if.sv
// Interface joining the processor end and the system end of the bus.
// Assumes one clock and the active-low asynchronous reset for both ends.
`timescale 1ns/10ps
interface sbsb_bus_if
    import sbsb_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i
);
    logic bus_req;
    logic bus_grant;
    logic xfer_start;
    logic [ADDR_W-1:0] addr;
    logic burst;
    logic read;
    logic [SIZE_W-1:0] size;
    logic inhibit;
    logic addr_ack;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic data_ack;
    logic quiesce_acknowledge_in;
    logic snoop_valid;
    logic [ADDR_W-1:0] snoop_addr;
    logic snoop_hit;

    modport dev (
        input bus_grant, addr_ack, rdata, data_ack, quiesce_acknowledge_in,
        input snoop_valid, snoop_addr,
        output bus_req, xfer_start, addr, burst, read, size, inhibit,
        output wdata, snoop_hit
    );

    modport sys (
        output bus_grant, addr_ack, rdata, data_ack, quiesce_acknowledge_in,
        output snoop_valid, snoop_addr,
        input bus_req, xfer_start, addr, burst, read, size, inhibit,
        input wdata, snoop_hit
    );
endinterface

// ### core/sbsb_cpu_end.sv
// Processor end of the system bus: arbitration request, address tenure,
// data beats sized by the start-up width strap, MEI state of one line.
// Assumes the system end on the same clock answers every tenure.
`timescale 1ns/10ps

// Function
// - Always no-retry; accepted beats never cancelled
// - Read beats forwarded one cycle sooner
// - Quiesce acknowledge level selects 32-bit mode
// - Width strap sampled at hard reset release
// - Narrow mode beat carries four bytes
// - Narrow: dword two beats, line eight
// - 32-bit address bus, 64-bit data bus
// - Bus owned only via external arbiter grant
// - Single and burst, memory and I/O
// - MEI line states, coherent with MESI agents
module sbsb_cpu_end
    import sbsb_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // System bus
    sbsb_bus_if.dev bus,
    // Load/store side requests
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_read_i,
    input wire logic req_burst_i,
    input wire logic req_io_i,
    input wire logic [SIZE_W-1:0] req_size_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [LINE_W-1:0] req_wdata_i,
    // Load data forwarding
    output logic ld_valid_o,
    output logic [DATA_W-1:0] ld_data_o,
    output logic [BEAT_CNT_W-1:0] ld_beat_o,
    output logic done_o,
    // Mode and coherence status
    output logic narrow_mode_o,
    output logic no_retry_mode_o,
    output sbsb_mei_t line_state_o
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REQ,
        ST_ADDR,
        ST_AACK,
        ST_DATA
    } sbsb_cpu_state_t;

    sbsb_cpu_state_t state;
    logic strap_taken;
    logic narrow;
    logic [BEAT_CNT_W-1:0] beat;
    logic [3:0] total;
    logic [ADDR_W-1:0] xaddr;
    logic xburst;
    logic xread;
    logic xio;
    logic [SIZE_W-1:0] xsize;
    logic [LINE_W-1:0] xwdata;
    logic [DATA_W-1:0] wdata;
    logic last_beat;
    logic [ADDR_W-LINE_OFS_BITS-1:0] tag;
    sbsb_mei_t mei;
    logic snoop_hit;

    // Beat k of the write line; narrow beats use the upper lane
    function automatic logic [DATA_W-1:0] wr_piece(
        input logic [LINE_W-1:0] line,
        input logic [BEAT_CNT_W-1:0] k,
        input logic is_narrow);
        logic [LINE_W-1:0] sh;
        sh = is_narrow ? (line << (int'(k) * 32)) : (line << (int'(k) * 64));
        return is_narrow ? {sh[LINE_W-1 -: 32], 32'h0}
                         : sh[LINE_W-1 -: DATA_W];
    endfunction

    function automatic logic tag_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-LINE_OFS_BITS-1:0] t);
        return a[ADDR_W-1:LINE_OFS_BITS] == t;
    endfunction

    // ------------------------------------------------------------
    // Start-up strap
    // ------------------------------------------------------------
    // strap at release
    // Taken on the first enabled edge after release; the far end holds
    // the level stable across that edge.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            narrow <= RESET_NARROW;
            strap_taken <= 1'b0;
        end else if (ce_i && !strap_taken) begin
            narrow <= (bus.quiesce_acknowledge_in == NARROW_STRAP_LEVEL);
            strap_taken <= 1'b1;
        end
    end

    assign narrow_mode_o = narrow;
    assign no_retry_mode_o = NO_RETRY_MODE;

    // ------------------------------------------------------------
    // Transaction sequencer
    // ------------------------------------------------------------
    assign req_ready_o = (state == ST_IDLE) && strap_taken;
    assign bus.bus_req = (state == ST_REQ);
    assign bus.xfer_start = (state == ST_ADDR);
    assign last_beat = ({1'b0, beat} + 4'h1) == total;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= ST_IDLE;
        end else if (ce_i) begin
            case (state)
                ST_IDLE: begin
                    if (req_valid_i && req_ready_o) begin
                        state <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (bus.bus_grant) begin
                        state <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    state <= ST_AACK;
                end
                ST_AACK: begin
                    if (bus.addr_ack) begin
                        state <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (bus.data_ack && last_beat) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            xaddr <= '0;
            xburst <= 1'b0;
            xread <= 1'b0;
            xio <= 1'b0;
            xsize <= '0;
            xwdata <= '0;
            total <= SINGLE_BEATS;
        end else if (ce_i && req_valid_i && req_ready_o) begin
            xaddr <= req_addr_i;
            xburst <= req_burst_i;
            xread <= req_read_i;
            xio <= req_io_i;
            xsize <= req_size_i;
            xwdata <= req_wdata_i;
            total <= sbsb_beats(narrow, req_burst_i, req_size_i);
        end
    end

    assign bus.addr = xaddr;
    assign bus.burst = xburst;
    assign bus.read = xread;
    assign bus.size = xsize;
    assign bus.inhibit = xio;
    assign bus.wdata = wdata;

    // ------------------------------------------------------------
    // Data beats
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            beat <= '0;
            wdata <= '0;
        end else if (ce_i) begin
            if (state == ST_AACK && bus.addr_ack) begin
                beat <= '0;
                wdata <= wr_piece(xwdata, '0, narrow);
            end else if (state == ST_DATA && bus.data_ack && !last_beat) begin
                beat <= beat + 3'h1;
                wdata <= wr_piece(xwdata, beat + 3'h1, narrow);
            end
        end
    end

    // beat is final once acknowledged
    // With no retry input a beat is final on its acknowledge, so it goes
    // to the load/store side on the next edge instead of a cycle later.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ld_valid_o <= 1'b0;
            ld_data_o <= '0;
            ld_beat_o <= '0;
            done_o <= 1'b0;
        end else if (ce_i) begin
            ld_valid_o <= (state == ST_DATA) && bus.data_ack && xread;
            if (state == ST_DATA && bus.data_ack && xread) begin
                ld_data_o <= bus.rdata;
                ld_beat_o <= beat;
            end
            done_o <= (state == ST_DATA) && bus.data_ack && last_beat;
        end
    end

    // ------------------------------------------------------------
    // Line coherence
    // ------------------------------------------------------------
    // MEI states
    // Shared is never kept: a snooped line is dropped instead, which stays
    // coherent beside four-state caches at the cost of refetches.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tag <= '0;
            mei <= SBSB_INVALID;
            snoop_hit <= 1'b0;
        end else if (ce_i) begin
            snoop_hit <= bus.snoop_valid && tag_hit(bus.snoop_addr, tag)
                         && (mei == SBSB_MODIFIED);
            if (bus.snoop_valid && tag_hit(bus.snoop_addr, tag)) begin
                mei <= SBSB_INVALID;
            end else if (state == ST_DATA && bus.data_ack && last_beat
                         && !xio) begin
                if (xburst && xread) begin
                    tag <= xaddr[ADDR_W-1:LINE_OFS_BITS];
                    mei <= SBSB_EXCLUSIVE;
                end else if (xburst && tag_hit(xaddr, tag)) begin
                    mei <= SBSB_INVALID;
                end else if (!xread && tag_hit(xaddr, tag)
                             && mei != SBSB_INVALID) begin
                    mei <= SBSB_MODIFIED;
                end
            end
        end
    end

    assign bus.snoop_hit = snoop_hit;
    assign line_state_o = mei;

endmodule

// ### core/sbsb_sys_end.sv
// System end of the bus: arbiter, width strap driver, memory slave and
// snoop source.
// Assumes the processor end on the same clock; other masters hold their
// request for as long as they own the bus.
`timescale 1ns/10ps
module sbsb_sys_end
    import sbsb_pkg::*;
#(
    parameter int MEM_DEPTH = MEM_DEPTH_DEFAULT
)
(
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // System bus
    sbsb_bus_if.sys bus,
    // Start-up width choice, held stable around reset release
    input wire logic narrow_sel_i,
    // Another bus master
    input wire logic other_req_i,
    output logic other_grant_o,
    // Snoop source
    input wire logic snoop_req_i,
    input wire logic [ADDR_W-1:0] snoop_addr_i,
    output logic snoop_dirty_o
);

    localparam int IDX_W = $clog2(MEM_DEPTH);

    typedef enum logic [1:0] {
        SL_IDLE,
        SL_ACK,
        SL_DATA
    } sbsb_sys_state_t;

    sbsb_sys_state_t state;
    logic narrow;
    logic strap_taken;
    logic cpu_owner;
    logic last_cpu;
    logic xread;
    logic [3:0] total;
    logic [3:0] beat;
    logic [IDX_W:0] pos;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    function automatic logic [DATA_W-1:0] rd_piece(
        input logic [DATA_W-1:0] dw,
        input logic is_narrow,
        input logic half);
        if (!is_narrow) begin
            return dw;
        end
        return half ? {dw[31:0], 32'h0} : {dw[63:32], 32'h0};
    endfunction

    // ------------------------------------------------------------
    // Width strap
    // ------------------------------------------------------------
    // drive strap level
    assign bus.quiesce_acknowledge_in = narrow_sel_i ? NARROW_STRAP_LEVEL
                                                     : ~NARROW_STRAP_LEVEL;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            narrow <= RESET_NARROW;
            strap_taken <= 1'b0;
        end else if (ce_i && !strap_taken) begin
            narrow <= narrow_sel_i;
            strap_taken <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Arbiter
    // ------------------------------------------------------------
    // single arbiter for all masters
    // Alternating priority keeps either master from starving the other.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cpu_owner <= 1'b0;
            other_grant_o <= 1'b0;
            last_cpu <= 1'b0;
        end else if (ce_i) begin
            if (cpu_owner) begin
                if (bus.xfer_start) begin
                    cpu_owner <= 1'b0;
                end
            end else if (other_grant_o) begin
                if (!other_req_i) begin
                    other_grant_o <= 1'b0;
                end
            end else if (state == SL_IDLE && bus.bus_req
                         && (!other_req_i || !last_cpu)) begin
                cpu_owner <= 1'b1;
                last_cpu <= 1'b1;
            end else if (state == SL_IDLE && other_req_i) begin
                other_grant_o <= 1'b1;
                last_cpu <= 1'b0;
            end
        end
    end

    assign bus.bus_grant = cpu_owner && !bus.xfer_start;

    // ------------------------------------------------------------
    // Memory slave
    // ------------------------------------------------------------
    assign bus.addr_ack = (state == SL_ACK);
    assign bus.data_ack = (state == SL_DATA);
    assign bus.rdata = rdata;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= SL_IDLE;
            xread <= 1'b0;
            total <= SINGLE_BEATS;
            beat <= '0;
            pos <= '0;
            rdata <= '0;
        end else if (ce_i) begin
            case (state)
                SL_IDLE: begin
                    if (bus.xfer_start) begin
                        xread <= bus.read;
                        total <= sbsb_beats(narrow, bus.burst, bus.size);
                        beat <= '0;
                        if (narrow) begin
                            pos <= bus.burst
                                ? {bus.addr[LINE_OFS_BITS +: IDX_W-2], 3'h0}
                                : bus.addr[2 +: IDX_W+1];
                        end else begin
                            pos <= bus.burst
                                ? {1'b0, bus.addr[LINE_OFS_BITS +: IDX_W-2],
                                   2'h0}
                                : {1'b0, bus.addr[3 +: IDX_W]};
                        end
                        state <= SL_ACK;
                    end
                end
                SL_ACK: begin
                    rdata <= narrow
                        ? rd_piece(mem[pos[IDX_W:1]], 1'b1, pos[0])
                        : mem[pos[IDX_W-1:0]];
                    state <= SL_DATA;
                end
                SL_DATA: begin
                    beat <= beat + 4'h1;
                    pos <= pos + 1'b1;
                    rdata <= narrow
                        ? rd_piece(mem[pos[IDX_W:1] + (IDX_W)'(pos[0])],
                                   1'b1, ~pos[0])
                        : mem[pos[IDX_W-1:0] + 1'b1];
                    if (beat + 4'h1 == total) begin
                        state <= SL_IDLE;
                    end
                end
                default: begin
                    state <= SL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i && reset_n_i && state == SL_DATA && !xread) begin
            if (!narrow) begin
                mem[pos[IDX_W-1:0]] <= bus.wdata;
            end else if (pos[0]) begin
                mem[pos[IDX_W:1]][31:0] <= bus.wdata[63:32];
            end else begin
                mem[pos[IDX_W:1]][63:32] <= bus.wdata[63:32];
            end
        end
    end

    // ------------------------------------------------------------
    // Snoop source
    // ------------------------------------------------------------
    // snoop for coherence
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus.snoop_valid <= 1'b0;
            bus.snoop_addr <= '0;
            snoop_dirty_o <= 1'b0;
        end else if (ce_i) begin
            bus.snoop_valid <= snoop_req_i;
            bus.snoop_addr <= snoop_addr_i;
            snoop_dirty_o <= bus.snoop_hit;
        end
    end

endmodule

// ### testbench/sbsb_monitor.sv
// Concurrent checks on the bus that joins the processor and system ends.
// Assumes it sits beside the interface and sees its signals as inputs.
`timescale 1ns/10ps
module sbsb_monitor
    import sbsb_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Bus signals
    input wire logic bus_grant,
    input wire logic xfer_start,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic burst,
    input wire logic [SIZE_W-1:0] size,
    input wire logic addr_ack,
    input wire logic data_ack,
    input wire logic quiesce_acknowledge_in,
    input wire logic snoop_valid,
    input wire logic snoop_hit
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // -----------------------------------------------------------------
    // Beat trains
    // -----------------------------------------------------------------
    // Strap is held while transfers run, so its level tells the width
    logic narrow;
    assign narrow = (quiesce_acknowledge_in == NARROW_STRAP_LEVEL);
    sequence s_two; data_ack [*2] ##1 !data_ack; endsequence
    sequence s_four; data_ack [*4] ##1 !data_ack; endsequence
    sequence s_eight; data_ack [*8] ##1 !data_ack; endsequence

    a_start_after_grant: assert property (
        xfer_start |-> $past(bus_grant)) else $error("start without grant");
    a_addr_ack_next: assert property (
        xfer_start |=> addr_ack) else $error("address not acknowledged");
    a_first_beat_next: assert property (
        addr_ack |=> data_ack) else $error("first beat late");
    a_addr_held: assert property (
        data_ack |-> $stable(addr)) else $error("address moved in tenure");
    a_wide_single_beat: assert property (
        addr_ack && !burst && !narrow |=> data_ack ##1 !data_ack)
        else $error("wide single not one beat");
    a_wide_line_beats: assert property (
        addr_ack && burst && !narrow |=> s_four)
        else $error("wide line not four beats");
    a_narrow_line_beats: assert property (
        addr_ack && burst && narrow |=> s_eight)
        else $error("narrow line not eight beats");
    a_narrow_dword_beats: assert property (
        addr_ack && !burst && narrow && size > NARROW_BEAT_BYTES |=> s_two)
        else $error("narrow dword not two beats");
    a_snoop_hit_cause: assert property (
        snoop_hit |-> $past(snoop_valid)) else $error("hit without snoop");
endmodule

// ### testbench/tb_top.sv
// Self-checking bench: both bus ends joined, user side driven here.
// Assumes memory content is written before it is read back.
`timescale 1ns/10ps
module tb_top
    import sbsb_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic narrow_sel_i, other_req_i, other_grant_o, snoop_req_i;
    logic snoop_dirty_o, req_valid_i, req_ready_o, req_read_i;
    logic req_burst_i, req_io_i, ld_valid_o, done_o;
    logic narrow_mode_o, no_retry_mode_o, m;
    logic [SIZE_W-1:0] req_size_i;
    logic [ADDR_W-1:0] req_addr_i, snoop_addr_i;
    logic [LINE_W-1:0] req_wdata_i;
    logic [DATA_W-1:0] ld_data_o;
    logic [BEAT_CNT_W-1:0] ld_beat_o;
    sbsb_mei_t line_state_o;
    int err_total = 0;
    int checks_done = 0;
    int cnt;

    always #10 clk_i = ~clk_i;

    sbsb_bus_if u_sbsb_bus_if (.clk_i(clk_i), .reset_n_i(reset_n_i));
    sbsb_cpu_end u_sbsb_cpu_end (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .ce_i(1'b1), .bus(u_sbsb_bus_if), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_read_i(req_read_i),
        .req_burst_i(req_burst_i), .req_io_i(req_io_i),
        .req_size_i(req_size_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .ld_valid_o(ld_valid_o),
        .ld_data_o(ld_data_o), .ld_beat_o(ld_beat_o), .done_o(done_o),
        .narrow_mode_o(narrow_mode_o), .no_retry_mode_o(no_retry_mode_o),
        .line_state_o(line_state_o));
    sbsb_sys_end #(.MEM_DEPTH(16)) u_sbsb_sys_end (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .ce_i(1'b1), .bus(u_sbsb_bus_if),
        .narrow_sel_i(narrow_sel_i), .other_req_i(other_req_i),
        .other_grant_o(other_grant_o), .snoop_req_i(snoop_req_i),
        .snoop_addr_i(snoop_addr_i), .snoop_dirty_o(snoop_dirty_o));
    sbsb_monitor u_sbsb_monitor (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .bus_grant(u_sbsb_bus_if.bus_grant),
        .xfer_start(u_sbsb_bus_if.xfer_start), .addr(u_sbsb_bus_if.addr),
        .burst(u_sbsb_bus_if.burst), .size(u_sbsb_bus_if.size),
        .addr_ack(u_sbsb_bus_if.addr_ack), .data_ack(u_sbsb_bus_if.data_ack),
        .quiesce_acknowledge_in(u_sbsb_bus_if.quiesce_acknowledge_in),
        .snoop_valid(u_sbsb_bus_if.snoop_valid),
        .snoop_hit(u_sbsb_bus_if.snoop_hit));

    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Strap must stay put past the first edge after release
    task do_reset(input logic nar);
        reset_n_i <= 1'b0;
        narrow_sel_i <= nar;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask

    // Narrow beats: only the upper half carries data, big end first
    function automatic logic [63:0] exp_beat(input int k);
        if (m)
            return {req_wdata_i[255-32*k -: 32], 32'h0};
        return req_wdata_i[255-64*k -: 64];
    endfunction

    task automatic xfer(input logic rd, input logic bu, input logic io,
                        input logic [3:0] sz, input logic [3:0] nb);
        int k;
        int n;
        logic pd;
        k = 0;
        n = 0;
        pd = 1'b0;
        @(negedge clk_i);
        while (req_ready_o !== 1'b1 && n < 50) begin
            @(negedge clk_i);
            n++;
        end
        chk(64'(req_ready_o), 64'h1);
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_read_i <= rd;
        req_burst_i <= bu;
        req_io_i <= io;
        req_size_i <= sz;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 60) begin
            @(negedge clk_i);
            n++;
            if (rd)
                chk(64'(ld_valid_o), 64'(pd));
            pd = u_sbsb_bus_if.data_ack;
            if ((rd ? ld_valid_o : pd) === 1'b1) begin
                if (rd)
                    chk(64'(ld_beat_o), 64'(k));
                if (rd)
                    chk(m ? {ld_data_o[63:32], 32'h0} : ld_data_o,
                        exp_beat(k));
                k++;
            end
        end
        chk(64'(done_o), 64'h1);
        chk(64'(k), 64'(nb));
    endtask

    initial begin
        narrow_sel_i = 1'b0;
        other_req_i = 1'b0;
        snoop_req_i = 1'b0;
        snoop_addr_i = 32'h0;
        req_valid_i = 1'b0;
        req_read_i = 1'b0;
        req_burst_i = 1'b0;
        req_io_i = 1'b0;
        req_size_i = 4'h0;
        req_addr_i = 32'h20;
        for (int i = 0; i < 8; i++)
            req_wdata_i[i*32 +: 32] = 32'h5a000000 + 32'(i);
        for (int j = 0; j < 2; j++) begin
            m = j[0];
            do_reset(m);
            @(negedge clk_i);
            chk(64'(narrow_mode_o), 64'(m));
            chk(64'(no_retry_mode_o), 64'h1);
            chk(64'(line_state_o), 64'(SBSB_INVALID));
            @(posedge clk_i);
            narrow_sel_i <= ~m;
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            chk(64'(narrow_mode_o), 64'(m));
            @(posedge clk_i);
            narrow_sel_i <= m;
            xfer(1'b0, 1'b1, 1'b0, 4'h8, m ? 4'h8 : 4'h4);
            xfer(1'b1, 1'b1, 1'b0, 4'h8, m ? 4'h8 : 4'h4);
            chk(64'(line_state_o), 64'(SBSB_EXCLUSIVE));
            xfer(1'b1, 1'b0, 1'b1, 4'h4, 4'h1);
            xfer(1'b1, 1'b0, 1'b1, 4'h8, m ? 4'h2 : 4'h1);
            xfer(1'b0, 1'b0, 1'b0, 4'h8, m ? 4'h2 : 4'h1);
            chk(64'(line_state_o), 64'(SBSB_MODIFIED));
            @(posedge clk_i);
            snoop_req_i <= 1'b1;
            snoop_addr_i <= 32'h20;
            @(posedge clk_i);
            snoop_req_i <= 1'b0;
            cnt = 0;
            repeat (6) @(negedge clk_i) cnt += int'(snoop_dirty_o === 1'b1);
            chk(64'(cnt), 64'h1);
            chk(64'(line_state_o), 64'(SBSB_INVALID));
            @(posedge clk_i);
            other_req_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            chk(64'(other_grant_o), 64'h1);
            chk(64'(u_sbsb_bus_if.bus_grant), 64'h0);
            @(posedge clk_i);
            other_req_i <= 1'b0;
            xfer(1'b1, 1'b1, 1'b0, 4'h8, m ? 4'h8 : 4'h4);
        end
        test_done;
    end

    // Whole run is well under a thousand cycles
    initial begin
        #200000;
        err_total++;
        test_done;
    end
endmodule
